/* hdl/pcl_pkg.sv */
// Overview of operation
// - count rising control-pin edges, decode count into sixteen current codes
// - code 1 gives 50/100 mA, higher codes lower, code 16 gives zero
// - codes 2 to 15 each sit one decibel below the code before them
// - pin high for latch timeout applies count as code and clears count
// - pin low past off timeout shuts down, disables outputs, clears count
// - edge trains from about 15 kHz to beyond 1 MHz are accepted
// - mode chosen from battery and sink-pin voltage comparisons
// - a sink nearing dropout in 1X starts the pump in 1.5X
// - a sink nearing dropout in 1.5X moves the pump to 2X
// - after start-up, test current per sink; disable sinks not pulled low
// - over-temperature shuts the charge pump down
//
// package of constants, types and the current table for the led driver control.
// assumes one 40 MHz clock and a free-running internal 1 MHz tick.
package pcl_pkg;

  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int OFF_TIMEOUT_US = 500;
  localparam int SOFTSTART_US = 100;
  localparam int TEST_CURRENT_US = 10;
  localparam int SOFTSTART_TICKS = SOFTSTART_US * (TICK_HZ / 1_000_000);
  localparam int TEST_TICKS = TEST_CURRENT_US * (TICK_HZ / 1_000_000);
  localparam int TMR_W = 16;
  localparam int CODE_W = 5;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h10;
  localparam int SINKS = 4;

  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int CTRL_PUMP_ALLOW_BIT = 0;
  localparam int CTRL_RETEST_BIT = 1;
  localparam logic PUMP_ALLOW_RESET = 1'h1;
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_CODE_LSB = 8;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_CHAN_LSB = 20;
  localparam int ST_ON_BIT = 24;
  localparam int ST_HOT_BIT = 25;

  typedef enum logic [2:0] {
    MODE_OFF, MODE_SOFTSTART, MODE_TEST, MODE_1X, MODE_1P5X, MODE_2X
  } pcl_mode_t;

  typedef struct packed {
    logic [6:0] sink_a_double;
    logic [5:0] sink_b_single;
    logic [5:0] sink_c_single;
    logic [6:0] sink_d_double;
  } pcl_sink_ma_t;

  typedef struct packed {
    logic [SINKS-1:0] near_dropout;
    logic [SINKS-1:0] below_thr;
    logic over_temp;
  } pcl_sense_t;

  // --------------------------------------------------------------
  // single-strength sink current in mA per code
  // --------------------------------------------------------------
  // one decibel steps
  function automatic logic [5:0] pcl_level_ma(input logic [CODE_W-1:0] code);
    logic [5:0] ma;
    ma = 6'h00;
    unique case (code)
      5'h01: ma = 6'h32;
      5'h02: ma = 6'h2c;
      5'h03: ma = 6'h28;
      5'h04: ma = 6'h24;
      5'h05: ma = 6'h20;
      5'h06: ma = 6'h1c;
      5'h07: ma = 6'h19;
      5'h08: ma = 6'h16;
      5'h09: ma = 6'h14;
      5'h0a: ma = 6'h11;
      5'h0b: ma = 6'h10;
      5'h0c: ma = 6'h0e;
      5'h0d: ma = 6'h0d;
      5'h0e: ma = 6'h0b;
      5'h0f: ma = 6'h0a;
      default: ma = 6'h00;
    endcase
    return ma;
  endfunction

endpackage

/* hdl/pcl_pulse_rx.sv */
// edge counter, latch timer and off timer for the pulse control pin.
// assumes pin is already synchronised and tick is a one-cycle 1 MHz enable.
`timescale 1ns/100ps
`default_nettype none
module pcl_pulse_rx
  import pcl_pkg::*;
#(
  parameter int LATCH_TICKS = LATCH_TIMEOUT_US,
  parameter int OFF_TICKS = OFF_TIMEOUT_US
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic pin,
  output logic [CODE_W-1:0] count,
  output logic [CODE_W-1:0] code,
  output logic enabled
);
  typedef struct packed {
    logic pin_d;
    logic [CODE_W-1:0] count;
    logic [CODE_W-1:0] code;
    logic enabled;
    logic [TMR_W-1:0] timer;
  } pcl_rx_st_t;

  pcl_rx_st_t s_ff;
  pcl_rx_st_t nxt_s;
  logic rise;
  logic latch_hit;
  logic off_hit;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.pin_d = pin;
    rise = pin & ~s_ff.pin_d;
    if (pin != s_ff.pin_d) begin
      nxt_s.timer = '0;
    end else if (tick && s_ff.timer != '1) begin
      nxt_s.timer = s_ff.timer + 16'h0001;
    end
    latch_hit = pin & s_ff.pin_d & (s_ff.count != '0) & (s_ff.timer >= TMR_W'(LATCH_TICKS));
    off_hit = ~pin & ~s_ff.pin_d & s_ff.enabled & (s_ff.timer >= TMR_W'(OFF_TICKS));
    if (rise) begin
      nxt_s.enabled = 1'b1;
      if (s_ff.count < CODE_MAX) begin
        nxt_s.count = s_ff.count + 5'h01;
      end
    end
    if (latch_hit) begin
      nxt_s.code = s_ff.count;
      nxt_s.count = '0;
    end
    if (off_hit) begin
      nxt_s.enabled = 1'b0;
      nxt_s.count = '0;
      nxt_s.code = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign count = s_ff.count;
  assign code = s_ff.code;
  assign enabled = s_ff.enabled;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_count_step: assert property (rise && s_ff.count < CODE_MAX |=> count == $past(count) + 5'h01)
    else $error("edge count did not advance");
  a_count_sat: assert property (rise && s_ff.count == CODE_MAX |=> count == CODE_MAX)
    else $error("edge count left saturation");
  a_latch_apply: assert property (latch_hit |=> code == $past(count) && count == '0)
    else $error("latch did not apply and clear");
  a_off_clear: assert property (off_hit |=> !enabled && count == '0 && code == '0)
    else $error("off timeout did not clear");
endmodule
`default_nettype wire

/* hdl/pcl_sync.sv */
// two-flop synchroniser for a vector of unrelated levels.
// assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/100ps
`default_nettype none
module pcl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcl_sync_st_t;

  pcl_sync_st_t s_ff;
  pcl_sync_st_t nxt_s;

  always_comb begin
    nxt_s.s1 = din;
    nxt_s.s2 = s_ff.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.s2;
endmodule
`default_nettype wire

/* hdl/pcl_top.sv */
// control logic of a flash led charge pump driver: pulse decoder,
// conversion mode selection, channel auto-disable, thermal gating, apb regs.
// assumes asynchronous pin and comparator inputs, 40 MHz CLK, apb master.
`timescale 1ns/100ps
`default_nettype none
module pcl_top
  import pcl_pkg::*;
#(
  parameter int LATCH_US = LATCH_TIMEOUT_US,
  parameter int OFF_US = OFF_TIMEOUT_US
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic EN_SET,
  input wire pcl_sense_t SENSE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output pcl_sink_ma_t SINK_MA,
  output logic [SINKS-1:0] CHAN_EN,
  output logic TEST_CURRENT_EN,
  output logic PUMP_RUN,
  output logic PUMP_DOUBLE,
  output logic LOAD_SWITCH_ON,
  output logic DEVICE_ON
);
  localparam int LATCH_TICKS = LATCH_US * (TICK_HZ / 1_000_000);
  localparam int OFF_TICKS = OFF_US * (TICK_HZ / 1_000_000);

  typedef struct packed {
    pcl_mode_t mode;
    logic [TMR_W-1:0] tmr;
    logic [5:0] div;
    logic [SINKS-1:0] chan_en;
    logic pump_allow;
    logic retest;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    pcl_sink_ma_t sink;
    logic pump_run;
    logic pump_double;
    logic load_sw;
    logic test_en;
    logic dev_on;
  } pcl_top_st_t;

  pcl_top_st_t s_ff;
  pcl_top_st_t nxt_s;

  // --------------------------------------------------------------
  // synchronisers and pulse receiver
  // --------------------------------------------------------------
  logic [$bits(pcl_sense_t):0] sync_out;
  pcl_sense_t sense_s;
  logic pin_s;
  logic tick;
  logic [CODE_W-1:0] rx_count;
  logic [CODE_W-1:0] rx_code;
  logic rx_en;

  pcl_sync #(.W($bits(pcl_sense_t) + 1)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din({SENSE, EN_SET}),
    .dout(sync_out)
  );

  assign sense_s = sync_out[$bits(pcl_sense_t):1];
  assign pin_s = sync_out[0];
  assign tick = (s_ff.div == 6'(TICK_DIV - 1));

  pcl_pulse_rx #(.LATCH_TICKS(LATCH_TICKS), .OFF_TICKS(OFF_TICKS)) u_rx (
    .clk(CLK),
    .nrst(NRST),
    .tick(tick),
    .pin(pin_s),
    .count(rx_count),
    .code(rx_code),
    .enabled(rx_en)
  );

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  logic any_near;
  logic active;
  logic apb_first;
  logic apb_commit;
  logic [5:0] level;
  logic [31:0] status_word;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.div = tick ? 6'h00 : s_ff.div + 6'h01;
    nxt_s.retest = 1'b0;
    any_near = |(sense_s.near_dropout & s_ff.chan_en);
    active = (s_ff.mode == MODE_1X) || (s_ff.mode == MODE_1P5X) || (s_ff.mode == MODE_2X);
    level = pcl_level_ma(rx_code);

    // apb slave: one wait state, answer on the second access cycle
    apb_first = PSEL & PENABLE & ~s_ff.pready;
    apb_commit = PSEL & PENABLE & s_ff.pready;
    status_word = '0;
    status_word[ST_COUNT_LSB +: CODE_W] = rx_count;
    status_word[ST_CODE_LSB +: CODE_W] = rx_code;
    status_word[ST_MODE_LSB +: 3] = s_ff.mode;
    status_word[ST_CHAN_LSB +: SINKS] = s_ff.chan_en;
    status_word[ST_ON_BIT] = s_ff.dev_on;
    status_word[ST_HOT_BIT] = sense_s.over_temp;
    nxt_s.pready = apb_first;
    nxt_s.pslverr = 1'b0;
    nxt_s.prdata = '0;
    if (apb_first) begin
      if (PADDR == CTRL_OFFSET) begin
        nxt_s.prdata[CTRL_PUMP_ALLOW_BIT] = s_ff.pump_allow;
      end else if (PADDR == STATUS_OFFSET) begin
        nxt_s.prdata = status_word;
      end else begin
        nxt_s.pslverr = 1'b1;
      end
    end
    if (apb_commit && PWRITE && PADDR == CTRL_OFFSET) begin
      nxt_s.pump_allow = PWDATA[CTRL_PUMP_ALLOW_BIT];
      nxt_s.retest = PWDATA[CTRL_RETEST_BIT];
    end

    // mode sequencer, timer runs on the 1 MHz tick
    if (tick && s_ff.tmr != '1) begin
      nxt_s.tmr = s_ff.tmr + 16'h0001;
    end
    unique case (s_ff.mode)
      MODE_OFF: begin
        nxt_s.tmr = '0;
        nxt_s.chan_en = '0;
        if (rx_en) begin
          nxt_s.mode = MODE_SOFTSTART;
        end
      end
      MODE_SOFTSTART: begin
        if (s_ff.tmr >= TMR_W'(SOFTSTART_TICKS)) begin
          nxt_s.mode = MODE_TEST;
          nxt_s.tmr = '0;
        end
      end
      MODE_TEST: begin
        // keep only sinks pulled below threshold
        if (s_ff.tmr >= TMR_W'(TEST_TICKS)) begin
          nxt_s.chan_en = sense_s.below_thr;
          nxt_s.mode = MODE_1X;
        end
      end
      MODE_1X: begin
        if (any_near && s_ff.pump_allow) begin
          nxt_s.mode = MODE_1P5X;
        end
      end
      MODE_1P5X: begin
        // droop in 1.5X moves to 2X
        if (!s_ff.pump_allow) begin
          nxt_s.mode = MODE_1X;
        end else if (any_near) begin
          nxt_s.mode = MODE_2X;
        end
      end
      MODE_2X: begin
        if (!s_ff.pump_allow) begin
          nxt_s.mode = MODE_1X;
        end
      end
      default: begin
        nxt_s.mode = MODE_OFF;
      end
    endcase
    if (active && s_ff.retest) begin
      nxt_s.mode = MODE_TEST;
      nxt_s.tmr = '0;
    end
    if (!rx_en) begin
      nxt_s.mode = MODE_OFF;
    end

    // registered outputs
    // sink levels from the latched code
    nxt_s.sink.sink_a_double = (active && s_ff.chan_en[0]) ? {level, 1'b0} : 7'h00;
    nxt_s.sink.sink_b_single = (active && s_ff.chan_en[1]) ? level : 6'h00;
    nxt_s.sink.sink_c_single = (active && s_ff.chan_en[2]) ? level : 6'h00;
    nxt_s.sink.sink_d_double = (active && s_ff.chan_en[3]) ? {level, 1'b0} : 7'h00;
    nxt_s.pump_run = (s_ff.mode == MODE_1P5X || s_ff.mode == MODE_2X) && !sense_s.over_temp;
    nxt_s.pump_double = (s_ff.mode == MODE_2X) && !sense_s.over_temp;
    nxt_s.load_sw = (s_ff.mode == MODE_1X);
    nxt_s.test_en = (s_ff.mode == MODE_TEST);
    nxt_s.dev_on = (s_ff.mode != MODE_OFF);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s_ff <= '0;
      s_ff.mode <= MODE_OFF;
      s_ff.pump_allow <= PUMP_ALLOW_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign PRDATA = s_ff.prdata;
  assign PREADY = s_ff.pready;
  assign PSLVERR = s_ff.pslverr;
  assign SINK_MA = s_ff.sink;
  assign CHAN_EN = s_ff.chan_en;
  assign TEST_CURRENT_EN = s_ff.test_en;
  assign PUMP_RUN = s_ff.pump_run;
  assign PUMP_DOUBLE = s_ff.pump_double;
  assign LOAD_SWITCH_ON = s_ff.load_sw;
  assign DEVICE_ON = s_ff.dev_on;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_pump_hot_off: assert property (sense_s.over_temp |=> !PUMP_RUN && !PUMP_DOUBLE)
    else $error("pump running while hot");
  a_step_to_1p5: assert property (s_ff.mode == MODE_1X && any_near && s_ff.pump_allow
      && rx_en && !s_ff.retest |=> s_ff.mode == MODE_1P5X ##1 LOAD_SWITCH_ON == 1'b0)
    else $error("dropout in 1X did not start 1.5X");
  a_step_to_2x: assert property (s_ff.mode == MODE_1P5X && any_near && s_ff.pump_allow
      && rx_en && !s_ff.retest |=> s_ff.mode == MODE_2X)
    else $error("dropout in 1.5X did not move to 2X");
  a_chan_test: assert property (s_ff.mode == MODE_TEST && s_ff.tmr >= TMR_W'(TEST_TICKS)
      && rx_en |=> CHAN_EN == $past(sense_s.below_thr))
    else $error("auto-disable result wrong");
  a_sink_level: assert property (active && s_ff.chan_en[1]
      |=> SINK_MA.sink_b_single == pcl_level_ma($past(rx_code)))
    else $error("sink level does not match code");
  a_double_sink: assert property (active && s_ff.chan_en[0]
      |=> SINK_MA.sink_a_double == {SINK_MA.sink_b_single, 1'b0} || !$past(s_ff.chan_en[1]))
    else $error("double sink not twice single");
  a_code16_zero: assert property (rx_code == CODE_MAX |=> SINK_MA == '0)
    else $error("code sixteen not zero current");
  a_off_outputs: assert property (!rx_en |=> ##1 SINK_MA == '0 && !PUMP_RUN && !DEVICE_ON)
    else $error("outputs alive after shutdown");
  a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("apb answer late");
  a_pump_mode_only: assert property (PUMP_RUN |-> $past(s_ff.mode) != MODE_1X)
    else $error("pump running in load-switch mode");

  // --------------------------------------------------------------
  // bus checks
  // --------------------------------------------------------------
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("apb ready held too long");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == '0)
    else $error("read data not cleared between answers");
  a_err_unmapped: assert property (PSEL && PENABLE && !PREADY && PADDR != CTRL_OFFSET
      && PADDR != STATUS_OFFSET |=> PSLVERR)
    else $error("unmapped access without error");
  a_err_mapped: assert property (PSEL && PENABLE && !PREADY && (PADDR == CTRL_OFFSET
      || PADDR == STATUS_OFFSET) |=> !PSLVERR)
    else $error("mapped access flagged as error");
  a_ctrl_write: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == CTRL_OFFSET
      |=> s_ff.pump_allow == $past(PWDATA[CTRL_PUMP_ALLOW_BIT]))
    else $error("pump allow write lost");

  // --------------------------------------------------------------
  // mode and output checks
  // --------------------------------------------------------------
  a_start_soft: assert property (s_ff.mode == MODE_OFF && rx_en
      |=> s_ff.mode == MODE_SOFTSTART)
    else $error("enable did not start soft-start");
  a_soft_hold: assert property (s_ff.mode == MODE_SOFTSTART && rx_en
      && s_ff.tmr < TMR_W'(SOFTSTART_TICKS) |=> s_ff.mode == MODE_SOFTSTART)
    else $error("soft-start cut short");
  a_retest_go: assert property (active && s_ff.retest && rx_en
      |=> s_ff.mode == MODE_TEST)
    else $error("retest did not rerun channel test");
  a_test_flag: assert property (TEST_CURRENT_EN |-> $past(s_ff.mode) == MODE_TEST)
    else $error("test current outside channel test");
  a_off_follow: assert property (s_ff.mode != MODE_OFF && !rx_en
      |=> s_ff.mode == MODE_OFF)
    else $error("shutdown did not stop the sequencer");
  a_chan_off: assert property (s_ff.mode == MODE_OFF |=> CHAN_EN == '0)
    else $error("channels enabled while off");
  a_idle_sinks: assert property (!active |=> SINK_MA == '0)
    else $error("sink current while not active");
  a_switch_excl: assert property (LOAD_SWITCH_ON |-> !PUMP_RUN)
    else $error("load switch and pump both on");
  a_no_pump_deny: assert property (s_ff.mode == MODE_1X && !s_ff.pump_allow
      |=> s_ff.mode != MODE_1P5X)
    else $error("pump started while not allowed");
  a_double_runs: assert property (PUMP_DOUBLE |-> PUMP_RUN)
    else $error("doubling without pump running");
endmodule
`default_nettype wire

/* verif/pcl_host_model.sv */
// host side of the pulse control pin: edge trains, latch hold, idle low.
// assumes the bench calls each task just after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module pcl_host_model #(
  parameter int LATCH_US = 40,
  parameter int OFF_US = 40
) (
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // ----------------------------------------
  // pin sequences
  // ----------------------------------------
  // whole edge count, high phases 50 ns to 30 us
  task automatic train(input int n, input int hi, input int lo);
    repeat (n) begin
      pin <= 1'b0;
      repeat (lo) @(posedge clk);
      pin <= 1'b1;
      repeat (hi) @(posedge clk);
    end
  endtask

  // high past the latch interval, timer jitter allowed for
  task automatic hold_high();
    pin <= 1'b1;
    repeat ((LATCH_US + 3) * 40) @(posedge clk);
  endtask

  task automatic hold_low();
    pin <= 1'b0;
    repeat ((OFF_US + 3) * 40) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* verif/pulse_count_led_current_ctrl_test.sv */
// self-checking bench: apb master, sense levels, host model on the pin.
// assumes shortened latch and off intervals of 40 us each.
`timescale 1ns/100ps
`default_nettype none
module pulse_count_led_current_ctrl_test;
  import pcl_pkg::*;
  localparam int LAT = 40;
  localparam int OFF = 40;
  logic clk, nrst, en_set, psel, penable, pwrite, pready, pslverr, saw_test;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pcl_sense_t sense;
  pcl_sink_ma_t sink_ma;
  logic [SINKS-1:0] chan_en;
  logic test_en, pump_run, pump_double, load_sw, device_on, err;
  int errors = 0;
  int compares = 0;
  int lvl [16] = '{50, 44, 40, 36, 32, 28, 25, 22, 20, 17, 16, 14, 13, 11, 10, 0};

  pcl_top #(.LATCH_US(LAT), .OFF_US(OFF)) uut (.CLK(clk), .NRST(nrst), .EN_SET(en_set),
    .SENSE(sense), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SINK_MA(sink_ma), .CHAN_EN(chan_en), .TEST_CURRENT_EN(test_en), .PUMP_RUN(pump_run),
    .PUMP_DOUBLE(pump_double), .LOAD_SWITCH_ON(load_sw), .DEVICE_ON(device_on));
  pcl_host_model #(.LATCH_US(LAT), .OFF_US(OFF)) host (.clk(clk), .pin(en_set));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial saw_test = 1'b0;
  always @(posedge clk) begin
    if (test_en === 1'b1) saw_test <= 1'b1;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits for pready however long; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic st_chk(input int code, input int cnt);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status code", 32'(code), 32'(rd[12:8]));
    chk("status count", 32'(cnt), 32'(rd[4:0]));
  endtask

  task automatic latch_chk(input int code);
    pcl_sink_ma_t e;
    int l;
    host.hold_high();
    l = lvl[code-1];
    e = '{sink_a_double: 7'(2 * l), sink_b_single: 6'(l), sink_c_single: 6'(l),
      sink_d_double: 7'(2 * l)};
    st_chk(code, 0);
    chk("sink_ma", 32'(e), 32'(sink_ma));
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    // all sinks in use, none tied off
    sense = '{near_dropout: 4'h0, below_thr: 4'hf, over_temp: 1'b0};
    repeat (4) @(posedge clk);
    chk("device_on", 32'h0, 32'(device_on));
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    host.train(1, 2, 12);
    host.hold_high();
    repeat (100 * 40) @(posedge clk);
    chk("saw test", 32'h1, 32'(saw_test));
    chk("chan_en", 32'hf, 32'(chan_en));
    chk("load switch", 32'h1, 32'(load_sw));
    for (int n = 1; n <= 16; n++) begin
      host.train(n, 2, 12);
      repeat (4) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("count", 32'(n), 32'(rd[4:0]));
      latch_chk(n);
    end
    host.train(20, 2, 12);
    latch_chk(16);
    host.train(3, 1200, 1400);
    latch_chk(3);
    sense.below_thr <= 4'b1011;
    apb(1'b1, CTRL_OFFSET, 32'h3);
    repeat (20 * 40) @(posedge clk);
    chk("chan_en retest", 32'hb, 32'(chan_en));
    sense.below_thr <= 4'hf;
    apb(1'b1, CTRL_OFFSET, 32'h3);
    repeat (20 * 40) @(posedge clk);
    chk("chan_en restored", 32'hf, 32'(chan_en));
    for (int s = 4; s <= 5; s++) begin
      sense.near_dropout <= 4'h1;
      @(posedge clk);
      sense.near_dropout <= 4'h0;
      repeat (10) @(posedge clk);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("mode", 32'(s), 32'(rd[18:16]));
      chk("pump_run", 32'h1, 32'(pump_run));
      chk("pump_double", 32'(s == 5), 32'(pump_double));
    end
    sense.over_temp <= 1'b1;
    repeat (8) @(posedge clk);
    chk("hot pump_run", 32'h0, 32'(pump_run));
    chk("hot pump_double", 32'h0, 32'(pump_double));
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("hot flag", 32'h1, 32'(rd[25]));
    chk("on flag", 32'h1, 32'(rd[24]));
    sense.over_temp <= 1'b0;
    repeat (8) @(posedge clk);
    chk("cool pump_double", 32'h1, 32'(pump_double));
    apb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (8) @(posedge clk);
    chk("no pump load switch", 32'h1, 32'(load_sw));
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl readback", 32'h0, rd);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    host.train(2, 2, 12);
    host.hold_low();
    chk("off device_on", 32'h0, 32'(device_on));
    chk("off sink_ma", 32'h0, 32'(sink_ma));
    chk("off chan_en", 32'h0, 32'(chan_en));
    st_chk(0, 0);
    chk("off on flag", 32'h0, 32'(rd[24]));
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
